//--- logic/diag_map.vh
// register offsets, field positions and state codes of the diagnostic bank
`ifndef DIAG_MAP_VH
`define DIAG_MAP_VH
`define OFS_STRING_FAULT_SUMMARY 8'h12
`define OFS_SEQUENCER_STATE_VIEW 8'h14
`define RST_STRING_FAULT_SUMMARY 16'h0000
`define RST_SEQUENCER_STATE_VIEW 16'h0000
`define BIT_RESERVED 15
`define BIT_BUS_TIMEOUT_FLAG 14
`define BIT_BUS_TIMEOUT_CLR 13
`define BIT_BAD_STRING_CFG_FLAG 12
`define BIT_BAD_STRING_CFG_CLR 11
`define BIT_STRING_FAULT_FLAG 10
`define BIT_STRING_FAULT_CLR 9
`define BIT_GROUND_SHORT_SEEN 8
`define BIT_INTERNAL_SHORT_SEEN 7
`define BIT_OPEN_STRING_SEEN 6
`define BIT_CHANNEL_LSB 0
`define SEQ_CODE_WIDTH 5
`define SEQ_DISABLED 5'h00
`define SEQ_REGULATOR_STARTUP 5'h01
`define SEQ_FUSE_LOAD 5'h02
`define SEQ_STANDBY 5'h03
`define SEQ_RAMPUP_FIRST 5'h04
`define SEQ_RAMPUP_LAST 5'h0F
`define SEQ_NORMAL 5'h10
`define SEQ_SHUTDOWN 5'h11
`define SEQ_ERROR_RECOVERY 5'h12
`define SEQ_EVERY_STRING_FAILED 5'h13
`endif

//--- logic/led_fault_and_state_diagnostics.v
// fault summary and sequencer state registers of the backlight driver
`timescale 1ns/1ps
`include "diag_map.vh"

// Operation
// - bit 14 flags serial-bus timeout
// - clear needs status and clear bits together
// - bit 13 clears the timeout flag
// - bit 12 bad config, bit 11 clears
// - bit 10 combined string fault, bit 9 clears
// - bit 8 shows ground short, cleared with combined
// - bit 7 internal short, cleared with combined
// - bit 6 open string, cleared with combined
// - bits 5..0 per-channel fault, read-only
// - state register bits 15..5 read zero
// - bits 4..0 report live sequencer state
// - converter ramp-up reports codes 4h..Fh
// - bit 15 reserved, reads zero
module led_fault_and_state_diagnostics #(
   parameter CHANNELS = 6,
   parameter ADDR_W = 8
) (
   input wire ref_clk,
   input wire reset,
   input wire [ADDR_W-1:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_wdata,
   output reg [15:0] reg_rdata_q,
   input wire bus_timeout_pin,
   input wire bad_string_cfg_pin,
   input wire open_string_pin,
   input wire internal_short_pin,
   input wire ground_short_pin,
   input wire [CHANNELS-1:0] channel_failed_pin,
   input wire [`SEQ_CODE_WIDTH-1:0] sequencer_state_code,
   output reg fault_irq_n_q
);
   // two-stage synchronisers for the fault detector levels
   localparam SYNC_W = 5 + CHANNELS;
   wire [SYNC_W-1:0] raw_in;
   reg [SYNC_W-1:0] sync1_q;
   reg [SYNC_W-1:0] sync2_q;
   reg [SYNC_W-1:0] sync3_q;
   wire timeout_s;
   wire bad_cfg_s;
   wire open_s;
   wire short_s;
   wire gnd_s;
   wire [CHANNELS-1:0] chan_s;
   wire timeout_rise;
   wire bad_cfg_rise;
   wire open_rise;
   wire short_rise;
   wire gnd_rise;
   wire summary_wr;
   wire timeout_flag;
   wire bad_cfg_flag;
   wire string_fault_flag;
   wire combined_clear;
   reg open_string_seen_q;
   reg internal_short_seen_q;
   reg ground_short_seen_q;
   reg [CHANNELS-1:0] channel_failed_q;
   reg [`SEQ_CODE_WIDTH-1:0] seq_code_q;
   reg [15:0] rdata_d;

   // ------------------------------------------------------------
   // input synchronisation
   // ------------------------------------------------------------
   assign raw_in = {channel_failed_pin, ground_short_pin, internal_short_pin,
                    open_string_pin, bad_string_cfg_pin, bus_timeout_pin};

   // third stage only exists for rising-edge detection
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         sync1_q <= {SYNC_W{1'b0}};
         sync2_q <= {SYNC_W{1'b0}};
         sync3_q <= {SYNC_W{1'b0}};
      end
      else
      begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   assign timeout_s = sync2_q[0];
   assign bad_cfg_s = sync2_q[1];
   assign open_s = sync2_q[2];
   assign short_s = sync2_q[3];
   assign gnd_s = sync2_q[4];
   assign chan_s = sync2_q[SYNC_W-1:5];
   // flags raise on a new fault, so a persisting level can still be cleared
   assign timeout_rise = timeout_s & ~sync3_q[0];
   assign bad_cfg_rise = bad_cfg_s & ~sync3_q[1];
   assign open_rise = open_s & ~sync3_q[2];
   assign short_rise = short_s & ~sync3_q[3];
   assign gnd_rise = gnd_s & ~sync3_q[4];

   // ------------------------------------------------------------
   // sticky fault flags
   // ------------------------------------------------------------
   assign summary_wr = reg_wr && (reg_addr == `OFS_STRING_FAULT_SUMMARY);

   paired_clear_flag u_timeout_flag (
      .ref_clk(ref_clk),
      .reset(reset),
      .fault_event(timeout_rise),
      .wr_strobe(summary_wr),
      .flag_bit(reg_wdata[`BIT_BUS_TIMEOUT_FLAG]),
      .clr_bit(reg_wdata[`BIT_BUS_TIMEOUT_CLR]),
      .flag_q(timeout_flag)
   );

   paired_clear_flag u_bad_cfg_flag (
      .ref_clk(ref_clk),
      .reset(reset),
      .fault_event(bad_cfg_rise),
      .wr_strobe(summary_wr),
      .flag_bit(reg_wdata[`BIT_BAD_STRING_CFG_FLAG]),
      .clr_bit(reg_wdata[`BIT_BAD_STRING_CFG_CLR]),
      .flag_q(bad_cfg_flag)
   );

   paired_clear_flag u_string_fault_flag (
      .ref_clk(ref_clk),
      .reset(reset),
      .fault_event(open_rise | short_rise | gnd_rise),
      .wr_strobe(summary_wr),
      .flag_bit(reg_wdata[`BIT_STRING_FAULT_FLAG]),
      .clr_bit(reg_wdata[`BIT_STRING_FAULT_CLR]),
      .flag_q(string_fault_flag)
   );

   // both bits of the pair needed
   assign combined_clear = summary_wr && reg_wdata[`BIT_STRING_FAULT_FLAG]
                           && reg_wdata[`BIT_STRING_FAULT_CLR];

   // ------------------------------------------------------------
   // detail indicators
   // ------------------------------------------------------------
   // bits 8..6 follow the combined flag, channel bits stay live; a new event beats the clear
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         open_string_seen_q <= 1'b0;
         internal_short_seen_q <= 1'b0;
         ground_short_seen_q <= 1'b0;
         channel_failed_q <= {CHANNELS{1'b0}};
      end
      else
      begin
         if (open_rise)
            open_string_seen_q <= 1'b1;
         else if (combined_clear)
            open_string_seen_q <= 1'b0;
         if (short_rise)
            internal_short_seen_q <= 1'b1;
         else if (combined_clear)
            internal_short_seen_q <= 1'b0;
         if (gnd_rise)
            ground_short_seen_q <= 1'b1;
         else if (combined_clear)
            ground_short_seen_q <= 1'b0;
         channel_failed_q <= chan_s;
      end
   end

   // ------------------------------------------------------------
   // sequencer state capture
   // ------------------------------------------------------------
   // live state code
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         seq_code_q <= `SEQ_DISABLED;
      end
      else
      begin
         seq_code_q <= sequencer_state_code;
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   // registered read data; unmapped offsets return zero
   always @*
   begin
      rdata_d = 16'h0000;
      case (reg_addr)
         `OFS_STRING_FAULT_SUMMARY:
         begin
            rdata_d[`BIT_RESERVED] = 1'b0;
            rdata_d[`BIT_BUS_TIMEOUT_FLAG] = timeout_flag;
            rdata_d[`BIT_BAD_STRING_CFG_FLAG] = bad_cfg_flag;
            rdata_d[`BIT_STRING_FAULT_FLAG] = string_fault_flag;
            rdata_d[`BIT_GROUND_SHORT_SEEN] = ground_short_seen_q;
            rdata_d[`BIT_INTERNAL_SHORT_SEEN] = internal_short_seen_q;
            rdata_d[`BIT_OPEN_STRING_SEEN] = open_string_seen_q;
            rdata_d[`BIT_CHANNEL_LSB +: CHANNELS] = channel_failed_q;
         end
         `OFS_SEQUENCER_STATE_VIEW:
         begin
            rdata_d[`SEQ_CODE_WIDTH-1:0] = seq_code_q;
         end
         default:
         begin
            rdata_d = 16'h0000;
         end
      endcase
   end

   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         reg_rdata_q <= `RST_STRING_FAULT_SUMMARY;
         fault_irq_n_q <= 1'b1;
      end
      else
      begin
         if (reg_rd)
            reg_rdata_q <= rdata_d;
         // pin indication drops one edge after the flags
         fault_irq_n_q <= ~(timeout_flag | bad_cfg_flag | string_fault_flag);
      end
   end
endmodule

//--- logic/paired_clear_flag.v
// one sticky fault flag cleared by a paired write-one
`timescale 1ns/1ps
module paired_clear_flag (
   input wire ref_clk,
   input wire reset,
   input wire fault_event,
   input wire wr_strobe,
   input wire flag_bit,
   input wire clr_bit,
   output reg flag_q
);
   reg flag_d;

   // set wins over clear so an event in the clearing cycle is kept
   always @*
   begin
      flag_d = flag_q;
      if (wr_strobe && flag_bit && clr_bit)
      begin
         flag_d = 1'b0;
      end
      if (fault_event)
      begin
         flag_d = 1'b1;
      end
   end

   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         flag_q <= 1'b0;
      end
      else
      begin
         flag_q <= flag_d;
      end
   end
endmodule

//--- testbench/diag_checker_properties.sv
// port assertions for the diagnostic register bank
`timescale 1ns/1ps
`include "diag_map.vh"
module diag_checker #(
   parameter CHANNELS = 6,
   parameter ADDR_W = 8
) (
   input wire ref_clk,
   input wire reset,
   input wire [ADDR_W-1:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_wdata,
   input wire [15:0] reg_rdata_q,
   input wire bus_timeout_pin,
   input wire bad_string_cfg_pin,
   input wire open_string_pin,
   input wire internal_short_pin,
   input wire ground_short_pin,
   input wire [CHANNELS-1:0] channel_failed_pin,
   input wire [`SEQ_CODE_WIDTH-1:0] sequencer_state_code,
   input wire fault_irq_n_q
);
   // ----------------
   // request decode
   // ----------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // pins quiet for four edges means no flag can be pending
   wire any_pin = bus_timeout_pin | bad_string_cfg_pin | open_string_pin | internal_short_pin | ground_short_pin;
   wire rd_sum = reg_rd && reg_addr == `OFS_STRING_FAULT_SUMMARY;
   wire rd_seq = reg_rd && reg_addr == `OFS_SEQUENCER_STATE_VIEW;
   wire wr_sum = reg_wr && reg_addr == `OFS_STRING_FAULT_SUMMARY;
   wire pair_hit = wr_sum && ((reg_wdata[14] & reg_wdata[13]) | (reg_wdata[12] & reg_wdata[11])
      | (reg_wdata[10] & reg_wdata[9]));
   sequence s_quiet;
      !any_pin [*4];
   endsequence
   sequence s_clear_all;
      wr_sum && reg_wdata[14:9] == 6'h3F;
   endsequence
   sequence s_steady_chan;
      $stable(channel_failed_pin) [*4];
   endsequence
   a_state_reserved: assert property (rd_seq |=> reg_rdata_q[15:5] == 11'h000)
      else $error("state view upper bits not zero");
   a_state_code: assert property (rd_seq && !$past(reset) |=> reg_rdata_q[4:0] == $past(sequencer_state_code, 2))
      else $error("state code read back wrong");
   a_summary_reserved: assert property (rd_sum |=> !reg_rdata_q[15])
      else $error("reserved summary bit set");
   a_channel_live: assert property (s_steady_chan ##0 rd_sum |=> reg_rdata_q[CHANNELS-1:0] == $past(channel_failed_pin))
      else $error("channel bits differ from pins");
   a_timeout_raise: assert property ($rose(bus_timeout_pin) |-> ##[1:6] !fault_irq_n_q)
      else $error("timeout fault not flagged");
   // the pin lags the flags by one edge, so a clear one cycle back may still release it
   a_flag_sticky: assert property (!fault_irq_n_q && !pair_hit && !$past(pair_hit) |=> !fault_irq_n_q)
      else $error("flag dropped without paired clear");
   a_clear_all: assert property (s_quiet ##0 s_clear_all |-> ##2 fault_irq_n_q)
      else $error("paired clear left indication low");
   a_reset_clean: assert property (disable iff (1'b0) reset [*2] |-> reg_rdata_q == 16'h0000 && fault_irq_n_q)
      else $error("outputs not clean in reset");
endmodule
bind led_fault_and_state_diagnostics diag_checker #(.CHANNELS(CHANNELS), .ADDR_W(ADDR_W)) u_chk (
   .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .bus_timeout_pin(bus_timeout_pin),
   .bad_string_cfg_pin(bad_string_cfg_pin), .open_string_pin(open_string_pin),
   .internal_short_pin(internal_short_pin), .ground_short_pin(ground_short_pin),
   .channel_failed_pin(channel_failed_pin), .sequencer_state_code(sequencer_state_code),
   .fault_irq_n_q(fault_irq_n_q));

//--- testbench/tb_top.sv
// self-checking bench for the diagnostic register bank
`timescale 1ns/1ps
`include "diag_map.vh"
module tb_top;
   reg ref_clk = 1'b0;
   reg reset = 1'b1;
   reg [7:0] reg_addr = 8'h00;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg [15:0] reg_wdata = 16'h0000;
   reg [4:0] pins = 5'h00;
   reg [5:0] chan = 6'h00;
   reg [4:0] code = 5'h00;
   reg rd_seen = 1'b0;
   wire [15:0] reg_rdata_q;
   wire fault_irq_n_q;
   logic [15:0] exp_q[$];
   integer err_total = 0;
   integer n_checks = 0;
   integer cycles = 0;
   integer i;
   // pin order: ground, short, open, bad config, timeout
   reg [15:0] flag_m [0:4] = '{16'h0500, 16'h0480, 16'h0440, 16'h1000, 16'h4000};
   reg [15:0] stat_m [0:4] = '{16'h0400, 16'h0400, 16'h0400, 16'h1000, 16'h4000};
   reg [4:0] codes [0:10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13};
   // ----------------
   // clock and design
   // ----------------
   initial forever #5 ref_clk = ~ref_clk;
   led_fault_and_state_diagnostics uut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .bus_timeout_pin(pins[4]), .bad_string_cfg_pin(pins[3]), .open_string_pin(pins[2]),
      .internal_short_pin(pins[1]), .ground_short_pin(pins[0]), .channel_failed_pin(chan),
      .sequencer_state_code(code), .fault_irq_n_q(fault_irq_n_q));
   task chk(input string what, input [15:0] e, input [15:0] got);
   begin
      n_checks = n_checks + 1;
      if (got !== e)
      begin
         err_total = err_total + 1;
         $display("[ERR] %s expected %h seen %h", what, e, got);
      end
   end
   endtask
   task wrap_up;
   begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask
   // read data lands one edge later; the falling edge avoids racing the update
   always @(posedge ref_clk)
      rd_seen <= reg_rd;
   always @(negedge ref_clk)
      if (rd_seen)
         chk("rdata", exp_q.pop_front(), reg_rdata_q);
   // hang guard, far above the few hundred cycles the tests need
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         err_total = err_total + 1;
         wrap_up;
      end
   end
   task rd(input [7:0] a, input [15:0] e);
   begin
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   end
   endtask
   task wr(input [7:0] a, input [15:0] d);
   begin
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   end
   endtask
   // ----------------
   // main sequence
   // ----------------
   initial
   begin
      i = $urandom(75);
      codes[5] = 5'h05 + 5'($urandom % 10);
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      rd(`OFS_STRING_FAULT_SUMMARY, `RST_STRING_FAULT_SUMMARY);
      rd(`OFS_SEQUENCER_STATE_VIEW, `RST_SEQUENCER_STATE_VIEW);
      rd(8'h13, 16'h0000);
      wr(8'h12, 16'hFFFF);
      rd(8'h12, 16'h0000);
      $display("reset test done");
      for (i = 0; i < 11; i = i + 1)
      begin
         code <= codes[i];
         repeat (2) @(posedge ref_clk);
         rd(8'h14, {11'h000, codes[i]});
      end
      $display("state test done");
      for (i = 0; i < 5; i = i + 1)
      begin
         chan <= 6'($urandom);
         pins <= 5'h01 << i;
         repeat (6) @(posedge ref_clk);
         @(negedge ref_clk);
         chk("irq_low", 16'h0000, {15'h0000, fault_irq_n_q});
         rd(8'h12, flag_m[i] | {10'h000, chan});
         wr(8'h12, stat_m[i]);
         wr(8'h12, stat_m[i] >> 1);
         rd(8'h12, flag_m[i] | {10'h000, chan});
         pins <= 5'h00;
         repeat (4) @(posedge ref_clk);
         wr(8'h12, stat_m[i] | (stat_m[i] >> 1));
         rd(8'h12, {10'h000, chan});
         @(negedge ref_clk);
         chk("irq_high", 16'h0001, {15'h0000, fault_irq_n_q});
         $display("fault test %0d done", i);
      end
      wrap_up;
   end
endmodule
